// >>> bwp_key_seq.sv
// Unlock key sequence tracker
`default_nettype none
`timescale 1ns/10ps
module bwp_key_seq (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Committed writes
   input  wire logic        key_wr,
   input  wire logic [31:0] key_data,
   input  wire logic        other_wr,
   // Result
   output var  logic        unlocked
);
   import bwp_pkg::*;

   logic first_q;
   logic unlocked_q;

   // ------------------------------------------------------------
   // Two keys back to back arm one register write
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_q    <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (key_wr) begin
         first_q    <= (key_data == KEY_FIRST);
         unlocked_q <= first_q && (key_data == KEY_SECOND);
      end else if (other_wr) begin
         first_q    <= 1'b0;
         unlocked_q <= 1'b0;
      end
   end

   assign unlocked = unlocked_q;
endmodule : bwp_key_seq
`default_nettype wire

// >>> bwp_page_check.sv
// Page protect lookup for one boot alias region
`default_nettype none
`timescale 1ns/10ps
module bwp_page_check #(
   parameter logic [31:0] BASE = 32'h0000_0000
) (
   // Address and protect bits
   input  wire logic [31:0] addr,
   input  wire logic [4:0]  protect,
   // Result
   output var  logic        hit
);
   import bwp_pkg::*;

   logic [31:0] offset;

   // ------------------------------------------------------------
   // One bit per 16 KB page
   // ------------------------------------------------------------
   always_comb begin
      offset = addr - BASE;
      hit    = 1'b0;
      if ((addr >= BASE) && (offset[31:PAGE_SHIFT] < 18'(PAGE_COUNT))) begin
         hit = protect[offset[PAGE_SHIFT+2:PAGE_SHIFT]];
      end
   end
endmodule : bwp_page_check
`default_nettype wire

// >>> bwp_pkg.sv
// Package of constants for the boot page write-protect block
// Operation
// - Lower page bits change only while the lower unlock bit (15) reads one.
// - Lower unlock bit clears on software write, never sets; only reset sets.
// - Upper page bits change only while the upper unlock bit (7) reads one.
// - Upper unlock bit clears on software write, never sets; only reset sets.
// - Bit 8 protects lower page 0, ending at 0x1FC03FFF; one means protected.
// - Bits 9 to 12 protect lower pages 1 to 4, last ending 0x1FC13FFF.
// - Protect register writes count only right after the unlock key sequence.
// - Page bit changes need both the key sequence and its group unlock bit.
// - Bit 6 is reserved, reads one after reset, ignores writes.
// - Bits 31-16, 14-13 and 5 read zero and ignore writes.
`default_nettype none
package bwp_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int          ADDR_W           = 8;
   localparam logic [7:0]  OFS_PROTECT      = 8'h00;
   localparam logic [7:0]  OFS_KEY          = 8'h04;
   localparam logic [7:0]  OFS_FLASH_ADDR   = 8'h08;
   localparam logic [7:0]  OFS_FLASH_CMD    = 8'h0C;
   localparam logic [7:0]  OFS_FLASH_STAT   = 8'h10;
   // ------------------------------------------------------------
   // Protect register fields
   // ------------------------------------------------------------
   localparam int          LOWER_UNLOCK_BIT = 15;
   localparam int          LOWER_PAGE_LSB   = 8;
   localparam int          UPPER_UNLOCK_BIT = 7;
   localparam int          TOOL_BIT         = 6;
   localparam int          UPPER_PAGE_LSB   = 0;
   localparam int          PAGE_COUNT       = 5;
   localparam int          PAGE_SHIFT       = 14;
   localparam logic        UNLOCK_RESET     = 1'b1;
   localparam logic        TOOL_RESET       = 1'b1;
   localparam logic [4:0]  PAGE_RESET       = 5'h1F;
   localparam logic [31:0] LOWER_BASE       = 32'h1FC0_0000;
   localparam logic [31:0] UPPER_BASE       = 32'h1FC2_0000;
   // ------------------------------------------------------------
   // Unlock keys, arbitrary values
   // ------------------------------------------------------------
   localparam logic [31:0] KEY_FIRST        = 32'h0000_A5A5;
   localparam logic [31:0] KEY_SECOND       = 32'h0000_5A5A;
   // ------------------------------------------------------------
   // Flash command and status fields
   // ------------------------------------------------------------
   localparam int          CMD_GO_BIT       = 0;
   localparam int          CMD_ERASE_BIT    = 1;
   localparam int          STAT_BUSY_BIT    = 0;
   localparam int          STAT_REFUSED_BIT = 1;
   localparam int          STAT_DONE_BIT    = 2;
   // ------------------------------------------------------------
   // Bus responses and states
   // ------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_DECERR      = 2'b11;
   typedef enum logic {
      BWP_FL_IDLE = 1'b0,
      BWP_FL_REQ  = 1'b1
   } bwp_flash_state_e;
endpackage : bwp_pkg
`default_nettype wire

// >>> bwp_top.sv
// Boot page write-protect register with AXI4-Lite slave and flash guard
`default_nettype none
`timescale 1ns/10ps
module bwp_top (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // Write address channel
   input  wire logic [bwp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                s_axi_awprot,
   input  wire logic                      s_axi_awvalid,
   output var  logic                      s_axi_awready,
   // Write data channel
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output var  logic                      s_axi_wready,
   // Write response channel
   output var  logic [1:0]                s_axi_bresp,
   output var  logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // Read address channel
   input  wire logic [bwp_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                s_axi_arprot,
   input  wire logic                      s_axi_arvalid,
   output var  logic                      s_axi_arready,
   // Read data channel
   output var  logic [31:0]               s_axi_rdata,
   output var  logic [1:0]                s_axi_rresp,
   output var  logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Flash controller request
   output var  logic                      flash_req,
   output var  logic                      flash_erase,
   output var  logic [31:0]               flash_addr,
   input  wire logic                      flash_ack,
   // Protect state
   output var  logic [4:0]                lower_page_protect,
   output var  logic [4:0]                upper_page_protect
);
   import bwp_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic                 awready_q;
   logic                 wready_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 arready_q;
   logic                 rvalid_q;
   logic [1:0]           rresp_q;
   logic [31:0]          rdata_q;
   logic                 aw_have_q;
   logic                 w_have_q;
   logic [ADDR_W-1:0]    awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic                 commit;
   logic                 aw_mapped;
   logic                 wr_protect;
   logic                 wr_key;
   logic                 wr_faddr;
   logic                 wr_cmd;
   logic                 key_unlocked;
   logic                 lower_unlock_q;
   logic                 upper_unlock_q;
   logic [4:0]           lower_page_q;
   logic [4:0]           upper_page_q;
   logic                 lower_unlock_d;
   logic                 upper_unlock_d;
   logic [4:0]           lower_page_d;
   logic [4:0]           upper_page_d;
   logic [31:0]          protect_view;
   logic [31:0]          faddr_q;
   logic [31:0]          flash_addr_q;
   logic                 flash_req_q;
   logic                 flash_erase_q;
   logic                 refused_q;
   logic                 done_q;
   bwp_flash_state_e     fl_state_q;
   logic                 cmd_go;
   logic                 target_hit;
   logic                 lower_hit;
   logic                 upper_hit;
   logic [31:0]          rd_word;
   logic [1:0]           rd_resp;

   // ------------------------------------------------------------
   // Write address and data capture
   // ------------------------------------------------------------
   assign commit = aw_have_q && w_have_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (commit) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (commit) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (commit) begin
         bvalid_q <= 1'b1;
         bresp_q  <= aw_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready && bvalid_q) begin
         bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   always_comb begin
      wr_protect = 1'b0;
      wr_key     = 1'b0;
      wr_faddr   = 1'b0;
      wr_cmd     = 1'b0;
      aw_mapped  = 1'b1;
      case (awaddr_q)
         OFS_PROTECT:    wr_protect = commit;
         OFS_KEY:        wr_key     = commit;
         OFS_FLASH_ADDR: wr_faddr   = commit;
         OFS_FLASH_CMD:  wr_cmd     = commit;
         OFS_FLASH_STAT: aw_mapped  = 1'b1;
         default:        aw_mapped  = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Unlock key sequence
   // ------------------------------------------------------------
   bwp_key_seq u_key (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .key_wr   (wr_key && (wstrb_q == 4'hF)),
      .key_data (wdata_q),
      .other_wr (commit && !(wr_key && (wstrb_q == 4'hF))),
      .unlocked (key_unlocked)
   );

   // ------------------------------------------------------------
   // Protect register next values
   // ------------------------------------------------------------
   always_comb begin
      lower_unlock_d = lower_unlock_q;
      upper_unlock_d = upper_unlock_q;
      lower_page_d   = lower_page_q;
      upper_page_d   = upper_page_q;
      if (wr_protect && key_unlocked) begin
         if (wstrb_q[1]) begin
            lower_unlock_d = lower_unlock_q && wdata_q[LOWER_UNLOCK_BIT];
            if (lower_unlock_q) begin
               lower_page_d = wdata_q[LOWER_PAGE_LSB +: PAGE_COUNT];
            end
         end
         if (wstrb_q[0]) begin
            upper_unlock_d = upper_unlock_q && wdata_q[UPPER_UNLOCK_BIT];
            if (upper_unlock_q) begin
               upper_page_d = wdata_q[UPPER_PAGE_LSB +: PAGE_COUNT];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Protect register state
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lower_unlock_q <= UNLOCK_RESET;
         upper_unlock_q <= UNLOCK_RESET;
         lower_page_q   <= PAGE_RESET;
         upper_page_q   <= PAGE_RESET;
      end else begin
         lower_unlock_q <= lower_unlock_d;
         upper_unlock_q <= upper_unlock_d;
         lower_page_q   <= lower_page_d;
         upper_page_q   <= upper_page_d;
      end
   end

   always_comb begin
      protect_view                                 = '0;
      protect_view[LOWER_UNLOCK_BIT]               = lower_unlock_q;
      protect_view[LOWER_PAGE_LSB +: PAGE_COUNT]   = lower_page_q;
      protect_view[UPPER_UNLOCK_BIT]               = upper_unlock_q;
      protect_view[TOOL_BIT]                       = TOOL_RESET;
      protect_view[UPPER_PAGE_LSB +: PAGE_COUNT]   = upper_page_q;
   end

   // ------------------------------------------------------------
   // Flash target address register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         faddr_q <= '0;
      end else if (wr_faddr) begin
         if (wstrb_q[0]) faddr_q[7:0]   <= wdata_q[7:0];
         if (wstrb_q[1]) faddr_q[15:8]  <= wdata_q[15:8];
         if (wstrb_q[2]) faddr_q[23:16] <= wdata_q[23:16];
         if (wstrb_q[3]) faddr_q[31:24] <= wdata_q[31:24];
      end
   end

   // ------------------------------------------------------------
   // Page lookup
   // ------------------------------------------------------------
   bwp_page_check #(
      .BASE (LOWER_BASE)
   ) u_lower_check (
      .addr    (faddr_q),
      .protect (lower_page_q),
      .hit     (lower_hit)
   );

   bwp_page_check #(
      .BASE (UPPER_BASE)
   ) u_upper_check (
      .addr    (faddr_q),
      .protect (upper_page_q),
      .hit     (upper_hit)
   );

   assign target_hit = lower_hit || upper_hit;
   assign cmd_go     = wr_cmd && wstrb_q[0] && wdata_q[CMD_GO_BIT];

   // ------------------------------------------------------------
   // Flash operation sequencer
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fl_state_q    <= BWP_FL_IDLE;
         flash_req_q   <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_addr_q  <= '0;
         refused_q     <= 1'b0;
         done_q        <= 1'b0;
      end else begin
         case (fl_state_q)
            BWP_FL_IDLE: begin
               if (cmd_go) begin
                  done_q <= 1'b0;
                  if (target_hit) begin
                     refused_q <= 1'b1;
                  end else begin
                     refused_q     <= 1'b0;
                     fl_state_q    <= BWP_FL_REQ;
                     flash_req_q   <= 1'b1;
                     flash_erase_q <= wdata_q[CMD_ERASE_BIT];
                     flash_addr_q  <= faddr_q;
                  end
               end
            end
            BWP_FL_REQ: begin
               if (flash_ack) begin
                  fl_state_q  <= BWP_FL_IDLE;
                  flash_req_q <= 1'b0;
                  done_q      <= 1'b1;
               end
            end
            default: begin
               fl_state_q  <= BWP_FL_IDLE;
               flash_req_q <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      rd_resp = RESP_OKAY;
      case (s_axi_araddr)
         OFS_PROTECT:    rd_word = protect_view;
         OFS_KEY:        rd_word = '0;
         OFS_FLASH_ADDR: rd_word = faddr_q;
         OFS_FLASH_CMD:  rd_word = '0;
         OFS_FLASH_STAT: begin
            rd_word[STAT_BUSY_BIT]    = (fl_state_q == BWP_FL_REQ);
            rd_word[STAT_REFUSED_BIT] = refused_q;
            rd_word[STAT_DONE_BIT]    = done_q;
         end
         default:        rd_resp = RESP_DECERR;
      endcase
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_resp;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready      = awready_q;
   assign s_axi_wready       = wready_q;
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = arready_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign flash_req          = flash_req_q;
   assign flash_erase        = flash_erase_q;
   assign flash_addr         = flash_addr_q;
   assign lower_page_protect = lower_page_q;
   assign upper_page_protect = upper_page_q;
endmodule : bwp_top
`default_nettype wire

// >>> bwp_top_sva.sv
// Checker for the boot page write-protect block
`default_nettype none
`timescale 1ns/10ps
module bwp_top_sva (
   // Clock and reset
   input wire logic                        aclk,
   input wire logic                        aresetn,
   // Read channels
   input wire logic [bwp_pkg::ADDR_W-1:0]  s_axi_araddr,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic [31:0]                 s_axi_rdata,
   input wire logic                        s_axi_rvalid,
   // Write response
   input wire logic                        s_axi_bvalid,
   // Flash and protect state
   input wire logic                        flash_req,
   input wire logic [31:0]                 flash_addr,
   input wire logic [4:0]                  lower_page_protect,
   input wire logic [4:0]                  upper_page_protect
);
   import bwp_pkg::*;
   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   logic [7:0]  ra_q;
   logic        lo_dead_q;
   logic        up_dead_q;
   logic        prd;
   logic [31:0] lo_off;
   logic [31:0] up_off;
   logic        lo_hit;
   logic        up_hit;
   assign prd    = s_axi_rvalid && ra_q == OFS_PROTECT;
   assign lo_off = flash_addr - LOWER_BASE;
   assign up_off = flash_addr - UPPER_BASE;
   assign lo_hit = lo_off < 32'h0001_4000 && |((5'h01 << lo_off[16:14]) & lower_page_protect);
   assign up_hit = up_off < 32'h0001_4000 && |((5'h01 << up_off[16:14]) & upper_page_protect);
   always_ff @(posedge aclk) begin
      if (!aresetn) ra_q <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_dead_q <= 1'b0;
         up_dead_q <= 1'b0;
      end else begin
         if (prd && !s_axi_rdata[15]) lo_dead_q <= 1'b1;
         if (prd && !s_axi_rdata[7]) up_dead_q <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   unimpl_zero_a: assert property (prd |-> s_axi_rdata[31:16] == 16'h0000
      && s_axi_rdata[14:13] == 2'h0 && !s_axi_rdata[5]) else $error("unused bits not zero");
   tool_bit_a: assert property (prd |-> s_axi_rdata[6]) else $error("tool bit not one");
   lower_map_a: assert property (prd |-> s_axi_rdata[12:8] == lower_page_protect)
      else $error("lower page map mismatch");
   upper_map_a: assert property (prd |-> s_axi_rdata[4:0] == upper_page_protect)
      else $error("upper page map mismatch");
   lo_sticky_a: assert property (prd && lo_dead_q |-> !s_axi_rdata[15])
      else $error("lower unlock set again");
   up_sticky_a: assert property (prd && up_dead_q |-> !s_axi_rdata[7])
      else $error("upper unlock set again");
   lo_frozen_a: assert property (lo_dead_q |=> $stable(lower_page_protect))
      else $error("locked lower pages changed");
   up_frozen_a: assert property (up_dead_q |=> $stable(upper_page_protect))
      else $error("locked upper pages changed");
   page_by_write_a: assert property ($changed(lower_page_protect)
      || $changed(upper_page_protect) |-> ##[0:2] s_axi_bvalid) else $error("page change without write");
   flash_guard_a: assert property ($rose(flash_req) |-> !lo_hit && !up_hit)
      else $error("request to protected page");
endmodule : bwp_top_sva
bind bwp_top bwp_top_sva u_sva (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .flash_req, .flash_addr, .lower_page_protect,
   .upper_page_protect);
`default_nettype wire

// >>> tb_bwp_top.sv
// Self-checking testbench for the boot page write-protect block
`default_nettype none
`timescale 1ns/10ps
module tb_bwp_top;
   import bwp_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] w_d = 32'h0, rdata, faddr;
   logic [3:0]  w_s = 4'h0;
   logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, ack = 1'b0;
   logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, freq, fer;
   logic [1:0]  bresp, rresp;
   logic [4:0]  lo_pg, up_pg;
   int          lo_u, up_u, lo_p, up_p, kst, bad_count = 0, total_checks = 0;
   logic [31:0] rnd = 32'h0000_0009;
   always #20 aclk = ~aclk;
   bwp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
      .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
      .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
      .s_axi_rready(r_r), .flash_req(freq), .flash_erase(fer), .flash_addr(faddr),
      .flash_ack(ack), .lower_page_protect(lo_pg), .upper_page_protect(up_pg));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic mdl(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      if (a == OFS_KEY && s == 4'hF && d == KEY_FIRST) kst = 1;
      else if (a == OFS_KEY && s == 4'hF && d == KEY_SECOND && kst == 1) kst = 2;
      else begin
         if (a == OFS_PROTECT && kst == 2) begin
            if (s[1] && lo_u == 1) lo_p = int'(d[12:8]);
            if (s[1]) lo_u = lo_u & int'(d[15]);
            if (s[0] && up_u == 1) up_p = int'(d[4:0]);
            if (s[0]) up_u = up_u & int'(d[7]);
         end
         kst = 0;
      end
   endtask : mdl
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic done;
      @(posedge aclk);
      done = 1'b0;
      aw_a <= a; w_d <= d; w_s <= s; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (aw_v && aw_rdy) aw_v <= 1'b0;
         if (w_v && w_rdy) w_v <= 1'b0;
         if (b_v && b_r) begin
            done = 1'b1;
            b_r <= 1'b0;
            chk(32'(bresp), 32'(er));
         end
      end
      mdl(a, d, s);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed);
      logic done;
      @(posedge aclk);
      done = 1'b0;
      ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (ar_v && ar_rdy) ar_v <= 1'b0;
         if (r_v && r_r) begin
            done = 1'b1;
            r_r <= 1'b0;
            chk(rdata, ed);
            chk(32'(rresp), 32'(RESP_OKAY));
         end
      end
   endtask : rd
   task automatic ck();
      rd(OFS_PROTECT, 32'(lo_u * 32768 + lo_p * 256 + up_u * 128 + 64 + up_p));
      chk(32'(lo_pg), 32'(lo_p));
      chk(32'(up_pg), 32'(up_p));
   endtask : ck
   task automatic kw();
      wr(OFS_KEY, KEY_FIRST, 4'hF, RESP_OKAY);
      wr(OFS_KEY, KEY_SECOND, 4'hF, RESP_OKAY);
   endtask : kw
   task automatic fl(input int pg, input logic up, input logic [31:0] off, input logic er);
      logic [31:0] ad;
      logic        prot;
      ad = (up ? UPPER_BASE : LOWER_BASE) + (32'(pg) << 14) + off;
      prot = up ? up_p[pg] : lo_p[pg];
      wr(OFS_FLASH_ADDR, ad, 4'hF, RESP_OKAY);
      rd(OFS_FLASH_ADDR, ad);
      wr(OFS_FLASH_CMD, {30'h0, er, 1'b1}, 4'hF, RESP_OKAY);
      chk(32'(freq), 32'(!prot));
      if (!prot) begin
         chk(faddr, ad);
         chk(32'(fer), 32'(er));
         rd(OFS_FLASH_STAT, 32'h1);
         repeat (pg) @(posedge aclk);
         ack <= 1'b1;
         @(posedge aclk);
         ack <= 1'b0;
      end
      rd(OFS_FLASH_STAT, prot ? 32'h2 : 32'h4);
   endtask : fl
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      #(40 * 20000);
      bad_count++;
      summarize();
   end
   initial begin
      lo_u = 1; up_u = 1; lo_p = 31; up_p = 31; kst = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      ck();
      wr(OFS_PROTECT, 32'h0, 4'hF, RESP_OKAY);
      ck();
      wr(OFS_KEY, KEY_FIRST, 4'hF, RESP_OKAY);
      wr(OFS_FLASH_ADDR, 32'h0, 4'hF, RESP_OKAY);
      wr(OFS_KEY, KEY_SECOND, 4'hF, RESP_OKAY);
      wr(OFS_PROTECT, 32'h0, 4'hF, RESP_OKAY);
      ck();
      kw();
      wr(OFS_PROTECT, 32'hFFFF_E0A0, 4'hF, RESP_OKAY);
      ck();
      kw();
      wr(OFS_PROTECT, 32'h0000_9F9F, 4'h2, RESP_OKAY);
      ck();
      kw();
      wr(OFS_PROTECT, 32'h0000_958A, 4'hF, RESP_OKAY);
      ck();
      for (int i = 0; i < 20; i++) fl(i % 5, (i / 5) % 2, (i / 10) ? 32'h3FFC : 32'h0, i % 2);
      wr(8'h20, 32'h0, 4'hF, RESP_DECERR);
      rd(OFS_KEY, 32'h0);
      kw();
      wr(OFS_PROTECT, 32'h0, 4'hF, RESP_OKAY);
      ck();
      kw();
      wr(OFS_PROTECT, 32'h0000_9FDF, 4'hF, RESP_OKAY);
      ck();
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         if (rnd[0]) kw();
         wr(OFS_PROTECT, rnd, rnd[19:16], RESP_OKAY);
         ck();
      end
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      lo_u = 1; up_u = 1; lo_p = 31; up_p = 31; kst = 0;
      ck();
      summarize();
   end
endmodule : tb_bwp_top
`default_nettype wire
